// file: cfg_page_pkg.sv
// Constants shared by the serial frame engine and the configuration register group.
// Assumes a 12-bit register address and 8-bit register data on the serial interface.
package cfg_page_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_PAGE_LOW = 12'h002;
    localparam logic [11:0] ADDR_PAGE_MID = 12'h003;
    localparam logic [11:0] ADDR_PAGE_HIGH = 12'h004;
    localparam logic [11:0] ADDR_WIRE_MODE = 12'h010;
    localparam logic [11:0] ADDR_CONV_PAGE = 12'h011;
    localparam logic [11:0] ADDR_TOP_PAGE = 12'h012;
    localparam logic [11:0] ADDR_POWER = 12'h020;
    localparam logic [11:0] ADDR_CHB_GATE = 12'h039;
    // First address that belongs to a selectable page
    localparam logic [11:0] ADDR_PAGED_BASE = 12'h020;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int WIRE_BIT = 0;
    localparam int TOP_BIT = 2;
    localparam int SYNC_OFF_BIT = 4;
    localparam int CHB_OFF_BIT = 1;
    localparam int SLEEP_BIT = 0;
    localparam int CHB_GATE_BIT = 1;
    localparam int TERM_DIS_BIT = 0;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic RESET_BIT = 1'b0;
    localparam logic [7:0] CONV_PAGE_ON = 8'hff;
    localparam logic [23:0] PAGE_MAIN_FIRST = 24'h68_0000;
    localparam logic [23:0] PAGE_MAIN_SECOND = 24'h68_0100;
    localparam logic [23:0] PAGE_FUNC_FIRST = 24'h61_0000;
    localparam logic [23:0] PAGE_FUNC_SECOND = 24'h61_0100;
    localparam logic [23:0] PAGE_LINK = 24'h69_0000;

    // ------------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------------
    localparam logic [4:0] HEADER_BITS = 5'h10;
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam int READ_FLAG_BIT = 14;

endpackage : cfg_page_pkg

// file: config_page_select_and_powerdown.sv
// Configuration register group with page selection and power-down controls.
// Assumes the host keeps the serial clock slower than a quarter of the system clock.
//
// Notes on behaviour
// R1 - Bytes 003h and 004h form page bits 23:8
// R2 - Byte 002h forms page bits 7:0
// R3 - Page 680000h/680100h selects main page per channel
// R4 - Page 610000h/610100h selects function page per channel
// R5 - Page 690000h selects the shared link page
// R6 - Wire bit one makes data pin bidirectional
// R7 - Wire bit zero keeps separate in and out
// R8 - Converter page selected only by all ones
// R9 - Host clears master bit with converter page
// R10 - Master bit maps accesses to master page
// R11 - Host clears converter page with master bit
// R12 - Sync buffer off blocks sync reference pulses
// R13 - Power-down bit one turns second channel off
// R14 - Sleep bit one puts whole chip down
// R15 - Second channel off needs gate bit set
// R16 - Next access sees writes; reserved bits zero
`timescale 1ns/1ps
module config_page_select_and_powerdown (
    input wire logic clock,
    input wire logic resetn,
    input wire logic enable,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic serial_in_pin_in,
    output logic serial_in_pin_out,
    output logic serial_in_pin_oe,
    output logic serial_out,
    input wire logic sync_ref_in,
    output logic sync_ref_out,
    output logic [23:0] bank_page,
    output logic main_first_page,
    output logic main_second_page,
    output logic func_first_page,
    output logic func_second_page,
    output logic link_page,
    output logic analog_page_on,
    output logic master_page_on,
    output logic three_wire,
    output logic sync_ref_buffer_off,
    output logic second_channel_off,
    output logic whole_chip_sleep,
    output logic sync_term_off
);

    // ------------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------------
    frame_if f ();

    serial_frame u_frame (
        .clock(clock),
        .resetn(resetn),
        .enable(enable),
        .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk),
        .serial_in_pin_in(serial_in_pin_in),
        .serial_in_pin_out(serial_in_pin_out),
        .serial_in_pin_oe(serial_in_pin_oe),
        .serial_out(serial_out),
        .f(f.shifter)
    );

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] page_low; // Page bits 7:0
        logic [7:0] page_mid; // Page bits 15:8
        logic [7:0] page_high; // Page bits 23:16
        logic wire_mode; // 3-wire form when set
        logic [7:0] conv_page; // Converter page selector
        logic top_page; // Master page select
        logic sync_off; // Sync buffer powered down
        logic chb_off; // Second channel power-down request
        logic sleep; // Whole chip power-down
        logic chb_gate; // Gate for the channel power-down
        logic term_dis; // Sync input termination off
        logic main_first; // Decoded page flags
        logic main_second;
        logic func_first;
        logic func_second;
        logic link;
        logic sync_ref_q; // Gated sync reference
    } regs_state_type;

    regs_state_type s_reg;
    regs_state_type s_next;
    logic general_addr; // Address below the paged space
    logic conv_sel; // Converter page currently selected
    logic [23:0] page_next; // Page selector after this cycle's write

    assign general_addr = f.addr < cfg_page_pkg::ADDR_PAGED_BASE;
    assign conv_sel = s_reg.conv_page == cfg_page_pkg::CONV_PAGE_ON; // R8

    // Register writes and decoded flags
    always_comb
    begin
        s_next = s_reg;
        page_next = '0;
        if (f.wr_stb)
        begin
            if (general_addr)
            begin
                // General registers are reachable from every page
                case (f.addr)
                    cfg_page_pkg::ADDR_PAGE_LOW: s_next.page_low = f.wdata; // R2
                    cfg_page_pkg::ADDR_PAGE_MID: s_next.page_mid = f.wdata; // R1
                    cfg_page_pkg::ADDR_PAGE_HIGH: s_next.page_high = f.wdata; // R1
                    cfg_page_pkg::ADDR_WIRE_MODE: s_next.wire_mode = f.wdata[cfg_page_pkg::WIRE_BIT]; // R6
                    cfg_page_pkg::ADDR_CONV_PAGE: s_next.conv_page = f.wdata; // R8
                    cfg_page_pkg::ADDR_TOP_PAGE: s_next.top_page = f.wdata[cfg_page_pkg::TOP_BIT]; // R10
                    default: s_next.page_low = s_reg.page_low;
                endcase
            end
            else if (conv_sel)
            begin
                // Converter page wins if both selects are set; its registers lie outside
                s_next.page_low = s_reg.page_low; // R9 R11
            end
            else if (s_reg.top_page)
            begin
                // Master page registers
                case (f.addr)
                    cfg_page_pkg::ADDR_POWER:
                    begin
                        s_next.sync_off = f.wdata[cfg_page_pkg::SYNC_OFF_BIT]; // R12
                        s_next.chb_off = f.wdata[cfg_page_pkg::CHB_OFF_BIT]; // R13
                        s_next.sleep = f.wdata[cfg_page_pkg::SLEEP_BIT]; // R14
                    end
                    cfg_page_pkg::ADDR_CHB_GATE:
                    begin
                        s_next.chb_gate = f.wdata[cfg_page_pkg::CHB_GATE_BIT]; // R15
                        s_next.term_dis = f.wdata[cfg_page_pkg::TERM_DIS_BIT];
                    end
                    default: s_next.sleep = s_reg.sleep;
                endcase
            end
        end
        // Page decode from the value that holds after this cycle
        page_next = {s_next.page_high, s_next.page_mid, s_next.page_low};
        s_next.main_first = page_next == cfg_page_pkg::PAGE_MAIN_FIRST; // R3
        s_next.main_second = page_next == cfg_page_pkg::PAGE_MAIN_SECOND; // R3
        s_next.func_first = page_next == cfg_page_pkg::PAGE_FUNC_FIRST; // R4
        s_next.func_second = page_next == cfg_page_pkg::PAGE_FUNC_SECOND; // R4
        s_next.link = page_next == cfg_page_pkg::PAGE_LINK; // R5
        // Sync reference pulses pass only while the buffer is powered
        s_next.sync_ref_q = sync_ref_in && !s_reg.sync_off; // R12
    end

    // State register, frozen while enable is low
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            s_reg <= '0;
            s_reg.page_low <= cfg_page_pkg::RESET_BYTE;
            s_reg.page_mid <= cfg_page_pkg::RESET_BYTE;
            s_reg.page_high <= cfg_page_pkg::RESET_BYTE;
            s_reg.conv_page <= cfg_page_pkg::RESET_BYTE;
            s_reg.wire_mode <= cfg_page_pkg::RESET_BIT; // R7
        end
        else if (enable)
            s_reg <= s_next;
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Reserved bits and unmapped addresses read as zero
    always_comb
    begin
        f.rdata = 8'h00;
        if (general_addr)
        begin
            case (f.addr)
                cfg_page_pkg::ADDR_PAGE_LOW: f.rdata = s_reg.page_low;
                cfg_page_pkg::ADDR_PAGE_MID: f.rdata = s_reg.page_mid;
                cfg_page_pkg::ADDR_PAGE_HIGH: f.rdata = s_reg.page_high;
                cfg_page_pkg::ADDR_WIRE_MODE: f.rdata[cfg_page_pkg::WIRE_BIT] = s_reg.wire_mode; // R16
                cfg_page_pkg::ADDR_CONV_PAGE: f.rdata = s_reg.conv_page;
                cfg_page_pkg::ADDR_TOP_PAGE: f.rdata[cfg_page_pkg::TOP_BIT] = s_reg.top_page; // R16
                default: f.rdata = 8'h00;
            endcase
        end
        else if (!conv_sel && s_reg.top_page)
        begin
            case (f.addr)
                cfg_page_pkg::ADDR_POWER:
                begin
                    f.rdata[cfg_page_pkg::SYNC_OFF_BIT] = s_reg.sync_off;
                    f.rdata[cfg_page_pkg::CHB_OFF_BIT] = s_reg.chb_off;
                    f.rdata[cfg_page_pkg::SLEEP_BIT] = s_reg.sleep;
                end
                cfg_page_pkg::ADDR_CHB_GATE:
                begin
                    f.rdata[cfg_page_pkg::CHB_GATE_BIT] = s_reg.chb_gate;
                    f.rdata[cfg_page_pkg::TERM_DIS_BIT] = s_reg.term_dis;
                end
                default: f.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign f.three_wire = s_reg.wire_mode; // R6
    assign three_wire = s_reg.wire_mode;
    assign bank_page = {s_reg.page_high, s_reg.page_mid, s_reg.page_low}; // R1 R2
    assign main_first_page = s_reg.main_first;
    assign main_second_page = s_reg.main_second;
    assign func_first_page = s_reg.func_first;
    assign func_second_page = s_reg.func_second;
    assign link_page = s_reg.link;
    assign analog_page_on = conv_sel;
    assign master_page_on = s_reg.top_page; // R10
    assign sync_ref_buffer_off = s_reg.sync_off;
    assign sync_ref_out = s_reg.sync_ref_q;
    // Channel power-down acts only through its gate
    assign second_channel_off = s_reg.chb_off && s_reg.chb_gate; // R13 R15
    assign whole_chip_sleep = s_reg.sleep; // R14
    assign sync_term_off = s_reg.term_dis;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    property p_mid_byte_write;
        enable && f.wr_stb && f.addr == cfg_page_pkg::ADDR_PAGE_MID |=> bank_page[15:8] == $past(f.wdata);
    endproperty
    a_mid_byte_write: assert property (p_mid_byte_write) else $error("middle page byte not stored"); // R1

    property p_low_byte_write;
        enable && f.wr_stb && f.addr == cfg_page_pkg::ADDR_PAGE_LOW |=> bank_page[7:0] == $past(f.wdata);
    endproperty
    a_low_byte_write: assert property (p_low_byte_write) else $error("low page byte not stored"); // R2

    property p_main_pages;
        (main_first_page |-> bank_page == cfg_page_pkg::PAGE_MAIN_FIRST) and (main_second_page |-> bank_page == cfg_page_pkg::PAGE_MAIN_SECOND) and (bank_page == cfg_page_pkg::PAGE_MAIN_SECOND |-> main_second_page);
    endproperty
    a_main_pages: assert property (p_main_pages) else $error("main page decode wrong"); // R3

    property p_func_pages;
        (func_first_page == (bank_page == cfg_page_pkg::PAGE_FUNC_FIRST)) && (func_second_page == (bank_page == cfg_page_pkg::PAGE_FUNC_SECOND));
    endproperty
    a_func_pages: assert property (p_func_pages) else $error("function page decode wrong"); // R4

    property p_link_page;
        link_page == (bank_page == cfg_page_pkg::PAGE_LINK);
    endproperty
    a_link_page: assert property (p_link_page) else $error("link page decode wrong"); // R5

    property p_pin_drive;
        serial_in_pin_oe |-> three_wire && !spi_cs_n;
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("data pin driven outside 3-wire read"); // R6 R7

    property p_analog_page;
        enable && f.wr_stb && f.addr == cfg_page_pkg::ADDR_CONV_PAGE
            |=> analog_page_on == ($past(f.wdata) == cfg_page_pkg::CONV_PAGE_ON);
    endproperty
    a_analog_page: assert property (p_analog_page) else $error("converter page decode wrong"); // R8

    property p_master_only;
        enable && f.wr_stb && f.addr == cfg_page_pkg::ADDR_POWER && !master_page_on |=> $stable(whole_chip_sleep) && $stable(sync_ref_buffer_off);
    endproperty
    a_master_only: assert property (p_master_only) else $error("power register written outside master page"); // R10

    property p_sync_block;
        sync_ref_buffer_off ##1 sync_ref_buffer_off |-> !sync_ref_out;
    endproperty
    a_sync_block: assert property (p_sync_block) else $error("sync pulse passed while buffer off"); // R12

    property p_chb_gate;
        second_channel_off |-> s_reg.chb_gate;
    endproperty
    a_chb_gate: assert property (p_chb_gate) else $error("channel off without gate"); // R13 R15

    // Channel power-down bit lands from a master page write, still gated
    property p_chb_off_write;
        enable && f.wr_stb && f.addr == cfg_page_pkg::ADDR_POWER
            && master_page_on && !analog_page_on
            |=> second_channel_off == ($past(f.wdata[cfg_page_pkg::CHB_OFF_BIT]) && s_reg.chb_gate);
    endproperty
    a_chb_off_write: assert property (p_chb_off_write) else $error("channel off bit not stored"); // R13 R15

    property p_sleep_write;
        enable && f.wr_stb && f.addr == cfg_page_pkg::ADDR_POWER && master_page_on && !analog_page_on |=> whole_chip_sleep == $past(f.wdata[0]);
    endproperty
    a_sleep_write: assert property (p_sleep_write) else $error("sleep bit not stored"); // R14

    property p_reserved_zero;
        f.addr == cfg_page_pkg::ADDR_TOP_PAGE |-> f.rdata[7:3] == 5'h00 && f.rdata[1:0] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero"); // R16

endmodule : config_page_select_and_powerdown

// file: config_page_select_and_powerdown_tb.sv
// Self-checking bench for the page select and power-down register group.
// Assumes the SPI host model drives every serial frame.
`timescale 1ns/1ps
module config_page_select_and_powerdown_tb;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic sync_ref_in = 1'b0;
    logic float_bit = 1'b0; // Undriven pin pattern
    logic spi_cs_n, spi_sclk, pin_drive, host_oe, pin_wire, pin_out, pin_oe, serial_out;
    logic sync_ref_out, mf, ms, ff, fs, lk, analog_page_on, master_page_on, three_wire;
    logic sync_ref_buffer_off, second_channel_off, whole_chip_sleep, sync_term_off;
    logic [23:0] bank_page;
    logic [7:0] rd;
    logic [23:0] p;
    logic [7:0] g, d;
    int seed = 92;
    int err_total = 0;
    int checks_done = 0;
    logic [23:0] codes [5] = '{24'h68_0000, 24'h68_0100, 24'h61_0000, 24'h61_0100, 24'h69_0000};

    always #2.5 clock = ~clock;
    always @(posedge clock) float_bit <= ~float_bit;
    // Shared pin level from both parties' enables
    assign pin_wire = pin_oe ? pin_out : (host_oe ? pin_drive : float_bit);

    config_page_select_and_powerdown config_page_select_and_powerdown_i (
        .clock(clock), .resetn(resetn), .enable(1'b1), .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk), .serial_in_pin_in(pin_wire), .serial_in_pin_out(pin_out),
        .serial_in_pin_oe(pin_oe), .serial_out(serial_out), .sync_ref_in(sync_ref_in),
        .sync_ref_out(sync_ref_out), .bank_page(bank_page), .main_first_page(mf),
        .main_second_page(ms), .func_first_page(ff), .func_second_page(fs), .link_page(lk),
        .analog_page_on(analog_page_on), .master_page_on(master_page_on),
        .three_wire(three_wire), .sync_ref_buffer_off(sync_ref_buffer_off),
        .second_channel_off(second_channel_off), .whole_chip_sleep(whole_chip_sleep),
        .sync_term_off(sync_term_off));

    spi_host_model spi_host_model_i (.clock(clock), .three_wire(three_wire),
        .serial_out(serial_out), .pin_wire(pin_wire), .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk), .pin_drive(pin_drive), .host_oe(host_oe));

    // Expected decode flags for a page value
    function automatic logic [4:0] flags(input logic [23:0] v);
        return {v == 24'h68_0000, v == 24'h68_0100, v == 24'h61_0000, v == 24'h61_0100,
            v == 24'h69_0000};
    endfunction : flags

    // Compare, count, report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        logic [7:0] dummy;
        spi_host_model_i.xfer(1'b0, a, v, dummy);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
        spi_host_model_i.xfer(1'b1, a, 8'h00, rd);
        chk(rd, exp);
    endtask : rdc

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (60000) @(posedge clock);
        err_total++;
        give_verdict();
    end

    initial
    begin
        repeat (3) @(posedge clock);
        #1 resetn = 1'b1;
        spi_host_model_i.tick(2);
        foreach (codes[k]) rdc(12'h002 + 12'(k), 8'h00);
        chk({three_wire, master_page_on, analog_page_on, bank_page}, 24'h0);
        $display("test reset done");
        for (int k = 0; k < 8; k++)
        begin
            p = k < 5 ? codes[k] : 24'($random(seed));
            wr(12'h004, p[23:16]);
            wr(12'h003, p[15:8]);
            wr(12'h002, p[7:0]);
            chk(bank_page, p);
            chk({mf, ms, ff, fs, lk}, flags(p));
            rdc(12'h003, p[15:8]);
        end
        $display("test pages done");
        wr(12'h012, 8'hff);
        rdc(12'h012, 8'h04);
        chk(master_page_on, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            g = k == 0 ? 8'h00 : (k == 1 ? 8'h02 : 8'($random(seed)));
            d = k < 2 ? 8'hff : 8'($random(seed));
            wr(12'h039, g);
            wr(12'h020, d);
            rdc(12'h020, d & 8'h13);
            rdc(12'h039, g & 8'h03);
            chk({sync_ref_buffer_off, second_channel_off, whole_chip_sleep, sync_term_off},
                {d[4], d[1] & g[1], d[0], g[0]});
            sync_ref_in = 1'b1;
            spi_host_model_i.tick(2);
            chk(sync_ref_out, !d[4]);
            sync_ref_in = 1'b0;
        end
        $display("test power done");
        wr(12'h012, 8'h00);
        wr(12'h011, 8'hff);
        chk({analog_page_on, master_page_on}, 2'b10);
        wr(12'h020, 8'h13);
        rdc(12'h020, 8'h00);
        wr(12'h011, 8'h7e);
        chk(analog_page_on, 1'b0);
        wr(12'h011, 8'h00);
        wr(12'h012, 8'h04);
        rdc(12'h020, d & 8'h13);
        $display("test converter page done");
        wr(12'h010, 8'hff);
        chk(three_wire, 1'b1);
        rdc(12'h010, 8'h01);
        rdc(12'h003, p[15:8]);
        wr(12'h010, 8'h00);
        rdc(12'h004, p[23:16]);
        $display("test wire mode done");
        give_verdict();
    end
endmodule : config_page_select_and_powerdown_tb

// file: frame_if.sv
// Carrier between the serial frame engine and the register group.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface frame_if;
    logic wr_stb; // One-cycle write strobe at end of a write frame
    logic [11:0] addr; // Register address of the frame
    logic [7:0] wdata; // Write data, valid with the strobe
    logic [7:0] rdata; // Read data for the current address
    logic three_wire; // Shared data pin mode

    modport shifter (output wr_stb, output addr, output wdata, input rdata, input three_wire);
    modport regs (input wr_stb, input addr, input wdata, output rdata, output three_wire);
endinterface : frame_if

// file: serial_frame.sv
// Serial frame engine: samples the serial pins and turns frames into register accesses.
// Assumes the serial clock stays high and low for at least two system clocks.
`timescale 1ns/1ps
module serial_frame (
    input wire logic clock,
    input wire logic resetn,
    input wire logic enable,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic serial_in_pin_in,
    output logic serial_in_pin_out,
    output logic serial_in_pin_oe,
    output logic serial_out,
    frame_if.shifter f
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sclk_q; // Last serial clock sample
        logic [4:0] count; // Bits taken in this frame
        logic [15:0] header; // Command and address bits
        logic [7:0] in_byte; // Write data bits
        logic [7:0] out_byte; // Read data still to send
        logic out_bit; // Bit on the data output
        logic is_read; // Frame is a read
        logic [11:0] addr; // Captured address
        logic load; // Load read data next cycle
        logic wr_stb; // Write strobe
    } shift_state_type;

    shift_state_type s_reg;
    shift_state_type s_next;
    logic rise;
    logic fall;

    assign rise = spi_sclk && !s_reg.sclk_q;
    assign fall = !spi_sclk && s_reg.sclk_q;

    // Next-state logic for the whole frame
    always_comb
    begin
        s_next = s_reg;
        s_next.wr_stb = 1'b0;
        s_next.load = 1'b0;
        s_next.sclk_q = spi_sclk;
        if (spi_cs_n)
        begin
            // Idle between frames
            s_next.count = 5'h00;
            s_next.out_bit = 1'b0;
            s_next.is_read = 1'b0;
        end
        else
        begin
            if (rise && s_reg.count < cfg_page_pkg::FRAME_BITS)
            begin
                // Take one bit on the rising serial clock
                if (s_reg.count < cfg_page_pkg::HEADER_BITS)
                    s_next.header = {s_reg.header[14:0], serial_in_pin_in};
                else
                    s_next.in_byte = {s_reg.in_byte[6:0], serial_in_pin_in};
                s_next.count = s_reg.count + 5'h01;
                if (s_reg.count == cfg_page_pkg::HEADER_BITS - 5'h01)
                begin
                    // Header complete: fix address and direction
                    s_next.addr = {s_reg.header[10:0], serial_in_pin_in};
                    s_next.is_read = s_reg.header[cfg_page_pkg::READ_FLAG_BIT];
                    s_next.load = 1'b1;
                end
                if (s_reg.count == cfg_page_pkg::FRAME_BITS - 5'h01 && !s_reg.is_read)
                    s_next.wr_stb = 1'b1;
            end
            // Fetch read data once the address is stable
            if (s_reg.load)
                s_next.out_byte = f.rdata;
            if (fall && s_reg.is_read && s_reg.count >= cfg_page_pkg::HEADER_BITS)
            begin
                // Send next read bit on the falling serial clock
                s_next.out_bit = s_reg.out_byte[7];
                s_next.out_byte = {s_reg.out_byte[6:0], 1'b0};
            end
        end
    end

    // State register, frozen while enable is low
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            s_reg <= '0;
        else if (enable)
            s_reg <= s_next;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign f.wr_stb = s_reg.wr_stb;
    assign f.addr = s_reg.addr;
    assign f.wdata = s_reg.in_byte;
    assign serial_in_pin_out = s_reg.out_bit;
    // Shared pin drives only in the read data phase of 3-wire form
    assign serial_in_pin_oe = f.three_wire && s_reg.is_read && !spi_cs_n && s_reg.count >= cfg_page_pkg::HEADER_BITS; // R6
    // Separate output carries read data in 4-wire form
    assign serial_out = f.three_wire ? 1'b0 : s_reg.out_bit; // R7

endmodule : serial_frame

// file: spi_host_model.sv
// SPI host model that frames register accesses towards the converter block.
// Assumes the block samples its pins on the rising edge of clock.
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clock,
    input wire logic three_wire,
    input wire logic serial_out,
    input wire logic pin_wire,
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic pin_drive,
    output logic host_oe
);
    // Idle: deselected, clock low, driving the shared pin
    initial
    begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        pin_drive = 1'b0;
        host_oe = 1'b1;
    end

    // Wait whole clocks, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    // One 24-bit frame, MSB first, four clocks per half period
    task automatic xfer(input logic rd_flag, input logic [11:0] addr, input logic [7:0] wd,
        output logic [7:0] rd);
        logic [23:0] word;
        word = {rd_flag, 3'h0, addr, wd};
        rd = 8'h00;
        spi_cs_n = 1'b0;
        tick(4);
        for (int i = 23; i >= 0; i--)
        begin
            spi_sclk = 1'b0;
            // Let go of the shared pin during read data in 3-wire form
            host_oe = !(three_wire && rd_flag && i < 8);
            pin_drive = word[i];
            tick(4);
            if (i < 8)
                rd[i] = three_wire ? pin_wire : serial_out;
            spi_sclk = 1'b1;
            tick(4);
        end
        spi_sclk = 1'b0;
        tick(4);
        spi_cs_n = 1'b1;
        host_oe = 1'b1;
        tick(4);
    endtask : xfer
endmodule : spi_host_model
